// [rtl/a2p_params.svh]
/*
 Constants of the bus bridge: bus codes, widths, select decode, divider.
 Assumes it is included by the package; the design modules use its macros without including it.
*/
`ifndef A2P_PARAMS_SVH
`define A2P_PARAMS_SVH

`define A2P_AW 32
`define A2P_DW 32
`define A2P_HT_NONSEQ 2'h2
`define A2P_HT_SEQ 2'h3
`define A2P_RESP_OKAY 2'h0
`define A2P_RESP_RETRY 2'h2
`define A2P_NSEL 16
`define A2P_SEL_LSB 12
`define A2P_SEL_W 4
`define A2P_DIV_W 4
`define A2P_PCLK_DIV 4'h4

`endif

// [rtl/a2p_pkg.sv]
/*
 Types of the bus bridge: queued transfer entry, state enums, select decode.
 Assumes a2p_params.svh is on the include path.
*/
package a2p_pkg;
`include "a2p_params.svh"

   typedef struct packed {
      logic [`A2P_AW-1:0] addr;
      logic write;
      logic [2:0] size;
      logic [`A2P_DW-1:0] wdata;
   } a2p_req_t;

   typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_WR, ST_RTY} a2p_ahb_st_t;
   typedef enum logic [1:0] {P_IDLE, P_SETUP, P_EN} a2p_apb_st_t;

   function automatic logic [`A2P_NSEL-1:0] a2p_sel_decode(input logic [`A2P_AW-1:0] addr);
      a2p_sel_decode = `A2P_NSEL'(1) << addr[`A2P_SEL_LSB +: `A2P_SEL_W];
   endfunction
endpackage

// [rtl/a2p_link_if.sv]
/*
 Link between the bus-facing half and the peripheral master of the bridge.
 Assumes one clock; the request entry and return data live in the bridge top.
*/
`timescale 1ns/1ps
interface a2p_link_if;
   import a2p_pkg::*;
   logic req_valid;
   a2p_req_t req;
   logic req_pop;
   logic ret_push;
   logic [`A2P_DW-1:0] ret_data;

   modport ahb (output req_valid, output req, input req_pop, input ret_push, input ret_data);
   modport apb (input req_valid, input req, output req_pop, output ret_push, output ret_data);
endinterface

// [rtl/a2p_apb_master.sv]
/*
 Peripheral-bus master of the bridge: setup and enable phases per queued
 transfer. Assumes i_pclk_en is a one-cycle pulse at the peripheral rate.
*/
`timescale 1ns/1ps
module a2p_apb_master
   import a2p_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_pclk_en,
   a2p_link_if.apb lk,
   output logic [`A2P_AW-1:0] o_paddr,
   output logic [`A2P_NSEL-1:0] o_psel,
   output logic o_penable,
   output logic o_pwrite,
   output logic [2:0] o_psize,
   output logic [`A2P_DW-1:0] o_pwdata,
   input wire logic [`A2P_DW-1:0] i_prdata
);
   typedef struct packed {
      a2p_apb_st_t st;
      a2p_req_t ent;
      logic [`A2P_NSEL-1:0] sel;
      logic penable;
   } a2p_apb_state_t;

   a2p_apb_state_t s;
   a2p_apb_state_t next_s;
   logic take;

   always_comb begin
      next_s = s;
      take = i_pclk_en && lk.req_valid && (s.st == P_IDLE || s.st == P_EN); // RULE12 RULE16
      lk.req_pop = take;
      lk.ret_push = i_pclk_en && s.st == P_EN && !s.ent.write; // RULE14 RULE15
      lk.ret_data = i_prdata;
      if (i_pclk_en) begin
         case (s.st)
            P_IDLE: begin
               next_s.st = P_IDLE;
            end
            P_SETUP: begin
               next_s.st = P_EN;
               next_s.penable = 1'b1; // RULE14
            end
            P_EN: begin
               next_s.st = P_IDLE;
               next_s.penable = 1'b0;
               next_s.sel = '0; // RULE24
            end
            default: begin
               next_s.st = P_IDLE;
            end
         endcase
         if (take) begin
            next_s.st = P_SETUP; // RULE13
            next_s.ent = lk.req; // RULE18 RULE19
            next_s.sel = a2p_sel_decode(lk.req.addr); // RULE17
            next_s.penable = 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s <= '{st: P_IDLE, ent: '0, sel: '0, penable: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign o_paddr = s.ent.addr;
   assign o_psel = s.sel;
   assign o_penable = s.penable;
   assign o_pwrite = s.ent.write;
   assign o_psize = s.ent.size;
   assign o_pwdata = s.ent.wdata; // RULE21

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   property p_one_sel;
      $onehot0(o_psel);
   endproperty
   a_one_sel: assert property (p_one_sel) else $error("More than one select"); // RULE17

   property p_setup_enable;
      (s.st == P_SETUP && i_pclk_en) |=> (o_penable && $stable(o_psel) && o_psel != '0);
   endproperty
   a_setup_enable: assert property (p_setup_enable) else $error("No enable after setup"); // RULE14

   property p_addr_stable;
      (s.st == P_SETUP) |=> $stable(o_paddr);
   endproperty
   a_addr_stable: assert property (p_addr_stable) else $error("Address moved"); // RULE18

   property p_start;
      lk.req_pop |-> lk.req_valid ##1 (s.st == P_SETUP && !o_penable);
   endproperty
   a_start: assert property (p_start) else $error("Bad start"); // RULE12
endmodule

// [rtl/a2p_bridge.sv]
/*
 Bus bridge top: system-bus slave with posted writes and split reads, a
 one-entry request queue, a one-entry return buffer, and the peripheral
 master. Assumes one clock; the peripheral rate is a divided enable.
*/
`timescale 1ns/1ps
// Function
// RULE1: Respond only when selected and bus ready
// RULE2: Accept NONSEQ and SEQ, ignore others
// RULE3: Write with full queue gets RETRY
// RULE4: Write with room: OKAY, one wait
// RULE5: Push write entry the next clock
// RULE6: Compare read address with record
// RULE7: Miss with outstanding read: RETRY
// RULE8: Miss, empty record, full queue: RETRY
// RULE9: Miss with room: queue the read
// RULE10: Hit without return data: RETRY
// RULE11: Hit with data: ready, OKAY, pop
// RULE12: Peripheral transfer starts only when queued
// RULE13: Setup phase drives address, select, data
// RULE14: Enable phase strobes and samples read
// RULE15: Sampled read data pushed to return
// RULE16: After enable, start next queued transfer
// RULE17: At most one peripheral select
// RULE18: Address held for whole transfer
// RULE19: Size carried with each transfer
// RULE20: Request queue one entry deep
// RULE21: Write data and read data paths
// RULE22: RETRY is two cycles; master repeats
// RULE23: Record loads on queue, clears on return
// RULE24: Idle drops enable and selects
module a2p_bridge
   import a2p_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic I_HSEL,
   input wire logic I_HREADY,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [2:0] I_HSIZE,
   input wire logic [`A2P_AW-1:0] I_HADDR,
   input wire logic [`A2P_DW-1:0] I_HWDATA,
   output logic O_HREADY,
   output logic [1:0] O_HRESP,
   output logic [`A2P_DW-1:0] O_HRDATA,
   output logic [`A2P_AW-1:0] O_PADDR,
   output logic [`A2P_NSEL-1:0] O_PSEL,
   output logic O_PENABLE,
   output logic O_PWRITE,
   output logic [2:0] O_PSIZE,
   output logic [`A2P_DW-1:0] O_PWDATA,
   input wire logic [`A2P_DW-1:0] I_PRDATA
);
   typedef struct packed {
      a2p_ahb_st_t st;
      logic [`A2P_AW-1:0] addr;
      logic write;
      logic [2:0] size;
      logic req_valid;
      a2p_req_t req;
      logic ret_valid;
      logic [`A2P_DW-1:0] ret_data;
      logic rec_valid;
      logic [`A2P_AW-1:0] rec_addr;
      logic [`A2P_DIV_W-1:0] div;
      logic pclk_en;
   } a2p_top_state_t;

   a2p_top_state_t s;
   a2p_top_state_t next_s;
   logic take;
   logic hit;
   logic retry;
   logic rd_ok;
   logic rd_queue;

   a2p_link_if lk ();

   // Single clock: the peripheral side advances on a divided enable pulse
   // and the one-entry queue is the hand-off between the two rates.
   always_comb begin
      next_s = s;
      O_HREADY = 1'b1;
      O_HRESP = `A2P_RESP_OKAY;
      retry = 1'b0;
      rd_ok = 1'b0;
      rd_queue = 1'b0;

      if (s.div == `A2P_PCLK_DIV - `A2P_DIV_W'(1)) begin
         next_s.div = '0;
         next_s.pclk_en = 1'b1;
      end else begin
         next_s.div = s.div + `A2P_DIV_W'(1);
         next_s.pclk_en = 1'b0;
      end

      if (lk.req_pop) begin
         next_s.req_valid = 1'b0;
      end

      // Full address only: a repeat with another size still hits
      hit = s.rec_valid && s.rec_addr == s.addr; // RULE6
      take = I_HSEL && I_HREADY && // RULE1
         (I_HTRANS == `A2P_HT_NONSEQ || I_HTRANS == `A2P_HT_SEQ); // RULE2

      case (s.st)
         ST_IDLE: begin
            next_s.st = ST_IDLE;
         end
         ST_DATA: begin
            if (s.write) begin
               // A pop in this very cycle still retries; costs one round trip
               if (s.req_valid) begin
                  retry = 1'b1; // RULE3
               end else begin
                  O_HREADY = 1'b0; // RULE4
                  next_s.st = ST_WR;
               end
            end else if (hit && s.ret_valid) begin
               rd_ok = 1'b1; // RULE11
               next_s.ret_valid = 1'b0;
               next_s.rec_valid = 1'b0; // RULE23
            end else if (hit) begin
               retry = 1'b1; // RULE10
            end else if (s.rec_valid) begin
               retry = 1'b1; // RULE7
            end else if (s.req_valid) begin
               retry = 1'b1; // RULE8
            end else begin
               // Queued and retried at once; the data waits for the repeat
               rd_queue = 1'b1; // RULE9
               retry = 1'b1;
               next_s.req_valid = 1'b1; // RULE20
               next_s.req = '{addr: s.addr, write: 1'b0, size: s.size, wdata: '0}; // RULE19
               next_s.rec_valid = 1'b1; // RULE23
               next_s.rec_addr = s.addr;
            end
            if (retry) begin
               O_HREADY = 1'b0; // RULE22
               O_HRESP = `A2P_RESP_RETRY;
               next_s.st = ST_RTY;
            end
         end
         ST_WR: begin
            // Write data stands in both data cycles; it is taken in the second
            next_s.req_valid = 1'b1; // RULE5 RULE20
            next_s.req = '{addr: s.addr, write: 1'b1, size: s.size, wdata: I_HWDATA};
         end
         ST_RTY: begin
            O_HRESP = `A2P_RESP_RETRY; // RULE22
         end
         default: begin
            next_s.st = ST_IDLE;
         end
      endcase

      // Set wins: a return push is applied after any pop of the buffer
      if (lk.ret_push) begin
         next_s.ret_valid = 1'b1; // RULE15
         next_s.ret_data = lk.ret_data;
      end

      if (O_HREADY) begin
         if (take) begin
            next_s.st = ST_DATA;
            next_s.addr = I_HADDR;
            next_s.write = I_HWRITE;
            next_s.size = I_HSIZE; // RULE19
         end else begin
            next_s.st = ST_IDLE;
         end
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Read data comes straight from the return buffer flop
   assign O_HRDATA = s.ret_data; // RULE21
   assign lk.req_valid = s.req_valid;
   assign lk.req = s.req;

   a2p_apb_master i_a2p_apb_master (
      .i_clk(I_CLK),
      .i_rst(I_RST),
      .i_pclk_en(s.pclk_en),
      .lk(lk.apb),
      .o_paddr(O_PADDR),
      .o_psel(O_PSEL),
      .o_penable(O_PENABLE),
      .o_pwrite(O_PWRITE),
      .o_psize(O_PSIZE),
      .o_pwdata(O_PWDATA),
      .i_prdata(I_PRDATA)
   );

   // System-side response shapes, then queue and record bookkeeping
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);

   sequence seq_wr_okay;
      (!O_HREADY && O_HRESP == `A2P_RESP_OKAY) ##1 (O_HREADY && O_HRESP == `A2P_RESP_OKAY);
   endsequence

   sequence seq_retry;
      (!O_HREADY && O_HRESP == `A2P_RESP_RETRY) ##1 (O_HREADY && O_HRESP == `A2P_RESP_RETRY);
   endsequence

   sequence seq_abandon;
      (!O_HREADY && O_HRESP == `A2P_RESP_RETRY) ##1
         (O_HREADY && O_HRESP == `A2P_RESP_RETRY && !s.rec_valid);
   endsequence

   sequence seq_rd_queued;
      (!O_HREADY && O_HRESP == `A2P_RESP_RETRY) ##1
         (O_HREADY && O_HRESP == `A2P_RESP_RETRY &&
         s.rec_valid && s.req_valid && !s.req.write);
   endsequence

   property p_unselected;
      (O_HREADY && !(I_HSEL && I_HREADY)) |=> s.st == ST_IDLE;
   endproperty
   a_unselected: assert property (p_unselected) else $error("Took unselected transfer"); // RULE1

   property p_idle_busy;
      (O_HREADY && !I_HTRANS[1]) |=> (s.st == ST_IDLE && O_HREADY);
   endproperty
   a_idle_busy: assert property (p_idle_busy) else $error("Took IDLE or BUSY"); // RULE2

   property p_wr_full;
      (s.st == ST_DATA && s.write && s.req_valid) |-> seq_retry;
   endproperty
   a_wr_full: assert property (p_wr_full) else $error("Full write not retried"); // RULE3

   property p_wr_okay;
      (s.st == ST_DATA && s.write && !s.req_valid) |-> seq_wr_okay;
   endproperty
   a_wr_okay: assert property (p_wr_okay) else $error("Write not OKAY with one wait"); // RULE4

   property p_wr_push;
      (s.st == ST_WR) |=> (s.req_valid && s.req.write && s.req.addr == $past(s.addr));
   endproperty
   a_wr_push: assert property (p_wr_push) else $error("Write entry not queued"); // RULE5

   property p_rd_busy;
      (s.st == ST_DATA && !s.write && s.rec_valid && s.rec_addr != s.addr) |-> seq_retry;
   endproperty
   a_rd_busy: assert property (p_rd_busy) else $error("Busy miss not retried"); // RULE7

   property p_rd_queue;
      rd_queue |-> seq_rd_queued;
   endproperty
   a_rd_queue: assert property (p_rd_queue) else $error("Read not queued"); // RULE9

   property p_rd_nodata;
      (s.st == ST_DATA && !s.write && hit && !s.ret_valid) |-> seq_retry;
   endproperty
   a_rd_nodata: assert property (p_rd_nodata) else $error("Hit without data not retried"); // RULE10

   property p_rd_ok;
      rd_ok |-> (O_HREADY && O_HRESP == `A2P_RESP_OKAY)
         ##1 (!s.rec_valid && !s.ret_valid);
   endproperty
   a_rd_ok: assert property (p_rd_ok) else $error("Hit with data not returned"); // RULE11 RULE23

   property p_one_deep;
      (s.req_valid && !lk.req_pop && s.st == ST_DATA && s.write) |-> O_HRESP == `A2P_RESP_RETRY;
   endproperty
   a_one_deep: assert property (p_one_deep) else $error("Queue overrun"); // RULE20

   property p_ret_catch;
      lk.ret_push |=> (s.ret_valid && s.ret_data == $past(I_PRDATA));
   endproperty
   a_ret_catch: assert property (p_ret_catch) else $error("Read data lost"); // RULE15 RULE21

   property p_pclk_pulse;
      s.pclk_en |=> !s.pclk_en;
   endproperty
   a_pclk_pulse: assert property (p_pclk_pulse) else $error("Enable wider than one cycle"); // RULE16

   property p_rd_full;
      (s.st == ST_DATA && !s.write && !s.rec_valid && s.req_valid) |-> seq_abandon;
   endproperty
   a_rd_full: assert property (p_rd_full) else $error("Full-queue read kept"); // RULE8

   property p_hit_okay;
      (s.st == ST_DATA && !s.write && hit && s.ret_valid) |->
         (O_HREADY && O_HRESP == `A2P_RESP_OKAY);
   endproperty
   a_hit_okay: assert property (p_hit_okay) else $error("Hit with data not OKAY"); // RULE11

   property p_data_phase;
      (O_HREADY && take) |=>
         (s.st == ST_DATA && s.addr == $past(I_HADDR) && s.write == $past(I_HWRITE));
   endproperty
   a_data_phase: assert property (p_data_phase) else $error("Not captured"); // RULE1 RULE2

   property p_idle_okay;
      (s.st == ST_IDLE) |-> (O_HREADY && O_HRESP == `A2P_RESP_OKAY);
   endproperty
   a_idle_okay: assert property (p_idle_okay) else $error("Idle not ready"); // RULE1 RULE2

   property p_retry_tail;
      (O_HREADY && O_HRESP == `A2P_RESP_RETRY) |->
         (!$past(O_HREADY) && $past(O_HRESP) == `A2P_RESP_RETRY);
   endproperty
   a_retry_tail: assert property (p_retry_tail) else $error("One-cycle retry"); // RULE22

   property p_wr_entry;
      (s.st == ST_WR) |=> (s.req.wdata == $past(I_HWDATA) && s.req.size == $past(s.size));
   endproperty
   a_wr_entry: assert property (p_wr_entry) else $error("Write entry wrong"); // RULE5 RULE19

   property p_rd_entry;
      rd_queue |=> (s.req.addr == $past(s.addr) && s.rec_addr == $past(s.addr)
         && s.req.size == $past(s.size));
   endproperty
   a_rd_entry: assert property (p_rd_entry) else $error("Read entry wrong"); // RULE9 RULE19

   property p_rec_hold;
      (s.rec_valid && !rd_ok) |=> (s.rec_valid && $stable(s.rec_addr));
   endproperty
   a_rec_hold: assert property (p_rec_hold) else $error("Record lost"); // RULE23

   property p_ret_hold;
      (s.ret_valid && !rd_ok) |=> (s.ret_valid && $stable(O_HRDATA));
   endproperty
   a_ret_hold: assert property (p_ret_hold) else $error("Return data lost"); // RULE10 RULE21

   property p_pop_clear;
      lk.req_pop |=> !s.req_valid;
   endproperty
   a_pop_clear: assert property (p_pop_clear) else $error("Entry kept after pop"); // RULE20

   property p_push_rec;
      lk.ret_push |-> (s.rec_valid && !s.ret_valid);
   endproperty
   a_push_rec: assert property (p_push_rec) else $error("Return without record"); // RULE15 RULE23

   property p_pclk_gap;
      s.pclk_en |-> ##4 s.pclk_en;
   endproperty
   a_pclk_gap: assert property (p_pclk_gap) else $error("Divider period wrong"); // RULE20
endmodule

// [testbench/a2p_apb_slave.sv]
/*
 Peripheral-bus slave model for the bridge bench: 16 words, zero wait.
 Assumes the bridge is the only master and no ready line exists.
*/
`timescale 1ns/1ps
module a2p_apb_slave
   import a2p_pkg::*;
(
   input wire logic i_clk,
   input wire logic [`A2P_AW-1:0] i_paddr,
   input wire logic [`A2P_NSEL-1:0] i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [`A2P_DW-1:0] i_pwdata,
   output logic [`A2P_DW-1:0] o_prdata
);
   logic [`A2P_DW-1:0] mem [16];
   logic [`A2P_DW-1:0] junk;
   initial begin
      junk = 32'h5A5A0000;
      for (int i = 0; i < 16; i++) begin
         mem[i] = 32'hC0DE0000 + 32'(i);
      end
   end
   always @(posedge i_clk) begin
      junk <= ~junk + 32'h1;
      if (|i_psel && i_penable && i_pwrite) begin
         mem[i_paddr[5:2]] <= i_pwdata;
      end
   end
   // Garbage outside the enable phase, so an early sample shows up
   assign o_prdata = (|i_psel && i_penable) ? mem[i_paddr[5:2]] : junk;
endmodule

// [testbench/ahb_to_apb_bridge_tb.sv]
/*
 Self-checking bench of the bus bridge: system-bus master tasks, a
 peripheral monitor and random traffic. Assumes the zero-wait slave model.
*/
`timescale 1ns/1ps
module ahb_to_apb_bridge_tb;
   import a2p_pkg::*;
   logic I_CLK, I_RST, I_HSEL, I_HREADY, I_HWRITE;
   logic [1:0] I_HTRANS, O_HRESP;
   logic [2:0] I_HSIZE, O_PSIZE;
   logic [31:0] I_HADDR, I_HWDATA, O_HRDATA, O_PADDR, O_PWDATA, I_PRDATA, psel_q, paddr_q;
   logic [15:0] O_PSEL;
   logic O_HREADY, O_PENABLE, O_PWRITE, pen_q;
   logic [31:0] shadow [16];
   logic [66:0] expq [$];
   logic [66:0] e;
   int num_errors, n_compared, seed, nrt, tot;
   logic [1:0] ig [4][3];

   a2p_bridge i_a2p_bridge (.I_CLK(I_CLK), .I_RST(I_RST), .I_HSEL(I_HSEL),
      .I_HREADY(I_HREADY), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HSIZE(I_HSIZE),
      .I_HADDR(I_HADDR), .I_HWDATA(I_HWDATA), .O_HREADY(O_HREADY), .O_HRESP(O_HRESP),
      .O_HRDATA(O_HRDATA), .O_PADDR(O_PADDR), .O_PSEL(O_PSEL), .O_PENABLE(O_PENABLE),
      .O_PWRITE(O_PWRITE), .O_PSIZE(O_PSIZE), .O_PWDATA(O_PWDATA), .I_PRDATA(I_PRDATA));
   a2p_apb_slave i_a2p_apb_slave (.i_clk(I_CLK), .i_paddr(O_PADDR), .i_psel(O_PSEL),
      .i_penable(O_PENABLE), .i_pwrite(O_PWRITE), .i_pwdata(O_PWDATA), .o_prdata(I_PRDATA));

   initial begin
      I_CLK = 0;
      forever #2 I_CLK = ~I_CLK;
   end

   task automatic complete_run;
      if (num_errors == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input logic ok, input string msg);
      n_compared++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask

   // One transfer; r1 is the first data-phase answer, nw the wait count
   task automatic xfer(input logic w, input logic [31:0] a, d, input logic [2:0] sz,
      output logic [1:0] r1, r, output logic [31:0] rd, output int nw);
      int k;
      I_HSEL = 1;
      I_HTRANS = `A2P_HT_NONSEQ;
      I_HWRITE = w;
      I_HADDR = a;
      I_HSIZE = sz;
      k = 0;
      do begin
         @(posedge I_CLK);
         k++;
      end while (O_HREADY !== 1'b1 && k < 50);
      #1;
      I_HTRANS = 2'h0;
      I_HWDATA = d;
      nw = 0;
      @(posedge I_CLK);
      r1 = O_HRESP;
      while (O_HREADY !== 1'b1 && nw < 50) begin
         nw++;
         @(posedge I_CLK);
      end
      r = O_HRESP;
      rd = O_HRDATA;
      #1;
   endtask

   task automatic wr(input logic [31:0] a, d, input logic [2:0] sz, output int n);
      logic [1:0] r1, r;
      logic [31:0] rd;
      int nw;
      n = 0;
      forever begin
         xfer(1'b1, a, d, sz, r1, r, rd, nw);
         if (r !== `A2P_RESP_RETRY || n > 100) break;
         check(r1 === `A2P_RESP_RETRY && nw == 1, "write retry shape");
         n++;
      end
      check(r === `A2P_RESP_OKAY && r1 === `A2P_RESP_OKAY && nw == 1, "write wait");
      shadow[a[5:2]] = d;
      expq.push_back({a, d, sz});
   endtask

   // Read repeated until OKAY, as a retried master must
   task automatic rdx(input logic [31:0] a, input logic [2:0] sz, input int first);
      logic [1:0] r1, r;
      logic [31:0] rd;
      int nw, n;
      n = 0;
      forever begin
         xfer(1'b0, a, 32'h0, sz, r1, r, rd, nw);
         if (r !== `A2P_RESP_RETRY || n > 200) break;
         check(r1 === `A2P_RESP_RETRY && nw == 1, "read retry shape");
         n++;
      end
      check(n >= first, "read not split");
      check(r === `A2P_RESP_OKAY && nw == 0, "read hit answer");
      check(rd === shadow[a[5:2]], "read data");
   endtask

   function automatic logic [31:0] rnd_addr(input int s);
      return {16'h0000, 4'(s), 6'h00, 4'($urandom), 2'h0};
   endfunction

   function automatic logic [15:0] exp_sel(input logic [31:0] a);
      return 16'h0001 << a[15:12];
   endfunction

   always @(posedge I_CLK) begin
      if (I_RST === 1'b0) begin
         if (O_PSEL === 16'h0000) check(O_PENABLE === 1'b0, "enable while idle");
         if (O_PENABLE === 1'b1) check(O_PSEL === exp_sel(O_PADDR), "sel");
         if (O_PENABLE === 1'b1 && pen_q !== 1'b1) begin
            check(O_PADDR === paddr_q && O_PSEL === psel_q[15:0], "setup");
            if (O_PWRITE === 1'b1) begin
               e = (expq.size() > 0) ? expq.pop_front() : '1;
               check({O_PADDR, O_PWDATA, O_PSIZE} === e, "queued write");
            end
         end
      end
      pen_q <= O_PENABLE;
      paddr_q <= O_PADDR;
      psel_q <= {16'h0000, O_PSEL};
   end

   initial begin
      #200000;
      num_errors++;
      complete_run();
   end

   initial begin
      logic [1:0] r1, r;
      logic [31:0] rd, a, b;
      int nw;
      {I_RST, I_HSEL, I_HREADY, I_HWRITE, I_HTRANS, I_HSIZE} = 9'h1_0_0;
      I_RST = 1;
      I_HREADY = 1;
      {I_HADDR, I_HWDATA} = 64'h0;
      ig = '{'{2'h1, 2'h1, 2'h0}, '{2'h1, 2'h1, 2'h1}, '{2'h0, 2'h1, 2'h2}, '{2'h1, 2'h0, 2'h2}};
      for (int i = 0; i < 16; i++) shadow[i] = 32'hC0DE0000 + 32'(i);
      seed = $urandom(46165);
      repeat (10) @(posedge I_CLK);
      #1;
      check(O_HREADY === 1'b1 && O_HRESP === 2'h0 && O_PSEL === 16'h0000, "reset");
      check(O_PENABLE === 1'b0 && O_HRDATA === 32'h0, "reset data");
      I_RST = 0;
      for (int i = 0; i < 4; i++) begin
         {I_HSEL, I_HREADY} = {ig[i][0][0], ig[i][1][0]};
         I_HTRANS = ig[i][2];
         I_HWRITE = 1;
         @(posedge I_CLK);
         #1;
         {I_HSEL, I_HREADY, I_HTRANS} = 4'h4;
         repeat (20) @(posedge I_CLK);
         check(O_HREADY === 1'b1 && O_HRESP === 2'h0 && O_PSEL === 16'h0000, "ignored");
         #1;
      end
      tot = 0;
      for (int i = 0; i < 4; i++) begin
         wr(rnd_addr(i), $urandom, 3'(i % 3), nrt);
         tot += nrt;
      end
      check(tot > 0, "no full queue");
      rdx(rnd_addr(5), 3'h2, 1);
      a = rnd_addr(7);
      xfer(1'b0, a, 32'h0, 3'h2, r1, r, rd, nw);
      check(r === `A2P_RESP_RETRY, "first read");
      b = {a[31:6], a[5:2] + 4'h1, 2'h0};
      xfer(1'b0, b, 32'h0, 3'h2, r1, r, rd, nw);
      check(r === `A2P_RESP_RETRY, "second read miss");
      rdx(a, 3'h2, 0);
      rdx(b, 3'h2, 1);
      for (int i = 0; i < 30; i++) begin
         a = rnd_addr($urandom);
         if ($urandom % 2) wr(a, $urandom, 3'($urandom % 3), nrt);
         else rdx(a, 3'($urandom % 3), 1);
      end
      repeat (40) @(posedge I_CLK);
      check(expq.size() == 0, "writes lost");
      check(O_PSEL === 16'h0000 && O_PENABLE === 1'b0, "not idle");
      complete_run();
   end
endmodule
